// ---- verilog/fls_pkg.sv ----
// Package with register map, field layout and timing constants of the flash sequencer
package fls_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] FLS_ADDR_CONTROL = 8'h10;
	localparam logic [7:0] FLS_ADDR_STATUS = 8'h14;
	localparam logic [7:0] FLS_CONTROL_RESET = 8'h00;
	localparam logic [31:0] FLS_UNMAPPED_READ = 32'h0000_0000;
	// ==========================================
	// Control field positions
	localparam int FLS_BIT_LEVEL_LO = 0;
	localparam int FLS_BIT_ARM = 2;
	localparam int FLS_BIT_BURST_LO = 3;
	localparam int FLS_BIT_PWM = 5;
	localparam int FLS_BIT_SAFETY = 6;
	// ==========================================
	// Level codes and duration codes
	localparam logic [1:0] FLS_LEVEL_FULL = 2'h3;
	localparam logic [1:0] FLS_BURST_FOLLOW = 2'h3;
	// ==========================================
	// Timing
	localparam int FLS_CLK_HZ = 100_000_000;
	localparam int FLS_BURST0_MS = 200;
	localparam int FLS_BURST1_MS = 400;
	localparam int FLS_BURST2_MS = 600;
	localparam int FLS_SAFETY_MS = 1200;
	localparam int FLS_CYC_PER_MS = FLS_CLK_HZ / 1000;
	localparam int FLS_BURST0_CYC = FLS_BURST0_MS * FLS_CYC_PER_MS;
	localparam int FLS_BURST1_CYC = FLS_BURST1_MS * FLS_CYC_PER_MS;
	localparam int FLS_BURST2_CYC = FLS_BURST2_MS * FLS_CYC_PER_MS;
	localparam int FLS_SAFETY_CYC = FLS_SAFETY_MS * FLS_CYC_PER_MS;
	// ==========================================
	// Sequencer states
	typedef enum logic [1:0] {
		FLS_ST_OFF = 2'b00,
		FLS_ST_TORCH = 2'b01,
		FLS_ST_BURST = 2'b10,
		FLS_ST_DONE = 2'b11
	} fls_state_t;
endpackage : fls_pkg

// ---- verilog/fls_edge_detect.sv ----
// Rising edge detector for a synchronous input
`timescale 1ns/100ps
module fls_edge_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level_in,
	output logic rise
);
	logic last_reg;
	logic last_next;

	always_comb begin
		last_next = level_in;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_reg <= 1'b0;
		end else begin
			last_reg <= last_next;
		end
	end

	assign rise = level_in & ~last_reg;
endmodule : fls_edge_detect

// ---- verilog/fls_burst_timer.sv ----
// Cycle counter that flags when a selected burst length has elapsed
`timescale 1ns/100ps
module fls_burst_timer #(
	parameter int CW = 28
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic run,
	input wire logic [CW-1:0] limit,
	output logic expired
);
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (clear) begin
			count_next = '0;
		end else if (run && !expired) begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign expired = (count_reg >= limit);
endmodule : fls_burst_timer

// ---- verilog/fls_sequencer.sv ----
// Flash LED sequencer: register slave, arm and burst state machine, sink control
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
// How it works
// - Arm clear keeps sink fully off, no bias.
// - Arm set enables sink at selected level.
// - Level code picks quarter, half, three-quarter, full.
// - Arming immediately gives torch current at level.
// - Trigger rise while armed fires full current.
// - Duration code 200/400/600 ms or trigger-follow.
// - Burst end shuts output off despite arm.
// - Re-arm needs arm written zero then one.
// - Hardware never clears arm bit itself.
// - Follow mode with safety stops after 1.2 s.
// - Control bit 5 enables external PWM gating.
module fls_sequencer
	import fls_pkg::*;
#(
	parameter int BURST0_CYC = FLS_BURST0_CYC,
	parameter int BURST1_CYC = FLS_BURST1_CYC,
	parameter int BURST2_CYC = FLS_BURST2_CYC,
	parameter int SAFETY_CYC = FLS_SAFETY_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic flash_trigger,
	input wire logic external_pwm_in,
	output logic sink_enable,
	output logic bias_enable,
	output logic [1:0] sink_level
);
	localparam int CW = 28;

	// ==========================================
	// Register state
	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	logic ack_next;
	fls_state_t state_reg;
	fls_state_t state_next;
	logic sink_reg;
	logic sink_next;
	logic bias_reg;
	logic bias_next;
	logic [1:0] level_reg;
	logic [1:0] level_next;

	logic flash_arm;
	logic [1:0] torch_level;
	logic [1:0] burst_length_sel;
	logic external_pwm_gate;
	logic safety_en;
	logic trig_rise;
	logic burst_done;
	logic safety_done;
	logic [CW-1:0] burst_limit;
	logic bus_take;
	logic ctl_write;
	logic [31:0] status_word;

	function automatic logic [CW-1:0] fls_burst_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: fls_burst_cycles = CW'(BURST0_CYC);
			2'h1: fls_burst_cycles = CW'(BURST1_CYC);
			2'h2: fls_burst_cycles = CW'(BURST2_CYC);
			default: fls_burst_cycles = CW'(SAFETY_CYC);
		endcase
	endfunction : fls_burst_cycles

	// Status word: sink, bias, spare zero, state code
	function automatic logic [31:0] fls_status_word(
		input fls_state_t st,
		input logic sink,
		input logic bias
	);
		fls_status_word = {27'h0, sink, bias, 1'b0, st};
	endfunction : fls_status_word

	assign flash_arm = control_reg[FLS_BIT_ARM];
	assign torch_level = control_reg[FLS_BIT_LEVEL_LO +: 2];
	assign burst_length_sel = control_reg[FLS_BIT_BURST_LO +: 2];
	assign external_pwm_gate = control_reg[FLS_BIT_PWM];
	assign safety_en = control_reg[FLS_BIT_SAFETY];
	assign burst_limit = fls_burst_cycles(burst_length_sel);

	// ==========================================
	// Submodules
	fls_edge_detect u_trig_edge (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(flash_trigger),
		.rise(trig_rise)
	);

	fls_burst_timer #(.CW(CW)) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.clear(state_reg != FLS_ST_BURST),
		.run(state_reg == FLS_ST_BURST),
		.limit(burst_limit),
		.expired(burst_done)
	);

	// In follow mode the limit is the safety time; only honoured with safety on
	assign safety_done = burst_done && safety_en;

	// ==========================================
	// Avalon-MM slave, one wait cycle per access
	// Request taken in its first cycle, answered in its second
	assign bus_take = (avs_read || avs_write) && !ack_reg;
	assign ctl_write = bus_take && avs_write && (avs_address == FLS_ADDR_CONTROL) && avs_byteenable[0];
	assign status_word = fls_status_word(state_reg, sink_reg, bias_reg);

	always_comb begin
		control_next = control_reg;
		rdata_next = rdata_reg;
		ack_next = 1'b0;
		if (bus_take) begin
			ack_next = 1'b1;
		end
		if (ctl_write) begin
			// Only software moves the arm bit
			control_next = avs_writedata[7:0];
		end
		if (bus_take && avs_read) begin
			case (avs_address)
				FLS_ADDR_CONTROL: rdata_next = {24'h00_0000, control_reg};
				FLS_ADDR_STATUS: rdata_next = status_word;
				default: rdata_next = FLS_UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= FLS_CONTROL_RESET;
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else begin
			control_reg <= control_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = bus_take;

	// ==========================================
	// Arm and burst sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FLS_ST_OFF: begin
				if (flash_arm) begin
					state_next = FLS_ST_TORCH;
				end
			end
			FLS_ST_TORCH: begin
				if (!flash_arm) begin
					state_next = FLS_ST_OFF;
				end else if (trig_rise) begin
					state_next = FLS_ST_BURST;
				end
			end
			FLS_ST_BURST: begin
				if (!flash_arm) begin
					state_next = FLS_ST_OFF;
				end else if (burst_length_sel == FLS_BURST_FOLLOW) begin
					if (!flash_trigger || safety_done) begin
						state_next = FLS_ST_DONE;
					end
				end else if (burst_done) begin
					state_next = FLS_ST_DONE;
				end
			end
			FLS_ST_DONE: begin
				if (!flash_arm) begin
					state_next = FLS_ST_OFF;
				end
			end
			default: state_next = FLS_ST_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= FLS_ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Sink drive, registered
	always_comb begin
		sink_next = 1'b0;
		bias_next = 1'b0;
		level_next = 2'h0;
		case (state_next)
			FLS_ST_TORCH: begin
				bias_next = 1'b1;
				sink_next = 1'b1;
				level_next = torch_level;
			end
			FLS_ST_BURST: begin
				bias_next = 1'b1;
				sink_next = 1'b1;
				level_next = FLS_LEVEL_FULL;
			end
			default: begin
				sink_next = 1'b0;
				bias_next = 1'b0;
				level_next = 2'h0;
			end
		endcase
		if (external_pwm_gate && !external_pwm_in) begin
			sink_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sink_reg <= 1'b0;
			bias_reg <= 1'b0;
			level_reg <= 2'h0;
		end else begin
			sink_reg <= sink_next;
			bias_reg <= bias_next;
			level_reg <= level_next;
		end
	end

	assign sink_enable = sink_reg;
	assign bias_enable = bias_reg;
	assign sink_level = level_reg;
endmodule : fls_sequencer

// ---- test/fls_sequencer_props.sv ----
// Port checks for the flash sequencer
`timescale 1ns/100ps
module fls_sequencer_props
	import fls_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic flash_trigger,
	input wire logic sink_enable,
	input wire logic bias_enable,
	input wire logic [1:0] sink_level
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ====
	// Trigger in torch mode, and outputs held off
	sequence s_fire;
		$rose(flash_trigger) && bias_enable && sink_level != FLS_LEVEL_FULL;
	endsequence
	chk_fire_full: assert property (s_fire |-> ##2 sink_level == FLS_LEVEL_FULL)
		else $error("burst not at full level");
	chk_stay_off: assert property (!bias_enable && !avs_write |=> !bias_enable)
		else $error("output came on without a write");
	chk_off_all: assert property (!bias_enable |-> !sink_enable && sink_level == 2'h0)
		else $error("sink active while bias off");
	// ====
	// Bus
	chk_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait cycle");
	chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait longer than one cycle");
	chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait while idle");
	chk_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address != FLS_ADDR_CONTROL
		&& avs_address != FLS_ADDR_STATUS |-> avs_readdata == FLS_UNMAPPED_READ)
		else $error("unmapped read not zero");
endmodule : fls_sequencer_props

// ---- test/fls_camera_model.sv ----
// Camera side: trigger pin and external PWM source
`timescale 1ns/100ps
module fls_camera_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [9:0] hold,
	input wire logic pwm_on,
	output logic flash_trigger,
	output logic external_pwm_in
);
	logic [9:0] cnt_reg = 10'h0;
	logic [1:0] ph_reg = 2'h0;
	// ====
	// Trigger high for hold cycles per request
	always @(posedge clk) begin
		cnt_reg <= go ? hold : (cnt_reg != 10'h0 ? cnt_reg - 10'h1 : cnt_reg);
		ph_reg <= ph_reg + 2'h1;
	end
	assign flash_trigger = cnt_reg != 10'h0;
	assign external_pwm_in = pwm_on & ph_reg[1];
endmodule : fls_camera_model

// ---- test/test_fls_sequencer.sv ----
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
module test_fls_sequencer;
	import fls_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0, pwm_on = 1'b0;
	logic [7:0] avs_address = 8'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [9:0] hold = 10'h0;
	logic avs_waitrequest, flash_trigger, external_pwm_in, sink_enable, bias_enable;
	logic [1:0] sink_level;
	wire [31:0] outs = {28'h0, bias_enable, sink_enable, sink_level};
	int num_errors = 0, tests_run = 0;
	always #5 clk = ~clk;
	fls_sequencer #(.BURST0_CYC(20), .BURST1_CYC(40), .BURST2_CYC(60), .SAFETY_CYC(120)) u_dut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .flash_trigger(flash_trigger), .external_pwm_in(external_pwm_in),
		.sink_enable(sink_enable), .bias_enable(bias_enable), .sink_level(sink_level));
	fls_camera_model u_cam (.clk(clk), .go(go), .hold(hold), .pwm_on(pwm_on),
		.flash_trigger(flash_trigger), .external_pwm_in(external_pwm_in));
	// ====
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		// Hold the request until waitrequest is sampled low at a rising edge
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic pulse;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask : pulse
	// ====
	// Scenarios
	task automatic t_regs;
		bus(0, FLS_ADDR_CONTROL, 8'h0);
		chk(q, {24'h0, FLS_CONTROL_RESET});
		bus(1, FLS_ADDR_CONTROL, 8'hc3);
		bus(0, FLS_ADDR_CONTROL, 8'h0);
		chk(q, 32'h0000_00c3);
		chk(outs, 32'h0);
		bus(0, 8'h08, 8'h0);
		chk(q, FLS_UNMAPPED_READ);
		bus(1, FLS_ADDR_CONTROL, 8'h0);
		$display("regs done");
	endtask : t_regs
	task automatic t_torch;
		for (int l = 0; l < 4; l++) begin
			bus(1, FLS_ADDR_CONTROL, 8'h04 | 8'(l));
			repeat (3) @(negedge clk);
			chk(outs, 32'hc | 32'(l));
			bus(0, FLS_ADDR_STATUS, 8'h0);
			chk(q, 32'h0000_0019);
			bus(1, FLS_ADDR_CONTROL, 8'h00);
			repeat (3) @(negedge clk);
			chk(outs, 32'h0);
		end
		$display("torch done");
	endtask : t_torch
	task automatic t_fire(input logic [7:0] ctl, input int hl, input int lim);
		int n = 0;
		bus(1, FLS_ADDR_CONTROL, ctl);
		hold <= 10'(hl);
		pulse();
		repeat (lim + 50) begin
			@(negedge clk);
			if (outs === 32'hf) n++;
		end
		chk(32'(n >= lim - 2 && n <= lim + 4), 32'h1);
		chk(outs, 32'h0);
		bus(0, FLS_ADDR_STATUS, 8'h0);
		chk(q, 32'h0000_0003);
		bus(0, FLS_ADDR_CONTROL, 8'h0);
		chk(q, {24'h0, ctl});
		repeat (hl) @(negedge clk);
		pulse();
		// Let the ignored trigger fall so the next test sees a fresh rise
		repeat (hl + 6) @(negedge clk);
		chk(outs, 32'h0);
		bus(1, FLS_ADDR_CONTROL, 8'h0);
		$display("fire %h done", ctl);
	endtask : t_fire
	task automatic t_pwm;
		logic p;
		bus(1, FLS_ADDR_CONTROL, 8'h24);
		pwm_on <= 1'b1;
		repeat (3) @(negedge clk);
		p = external_pwm_in;
		repeat (8) begin
			@(negedge clk);
			chk(32'(sink_enable), 32'(p));
			p = external_pwm_in;
		end
		bus(1, FLS_ADDR_CONTROL, 8'h0);
		pwm_on <= 1'b0;
		$display("pwm done");
	endtask : t_pwm
	task automatic wrap_up;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_torch();
		t_fire(8'h04, 5, 20);
		t_fire(8'h0c, 5, 40);
		t_fire(8'h14, 5, 60);
		t_fire(8'h1c, 30, 30);
		t_fire(8'h5c, 200, 120);
		t_pwm();
		wrap_up();
	end
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
endmodule : test_fls_sequencer
bind fls_sequencer fls_sequencer_props u_props (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.flash_trigger(flash_trigger), .sink_enable(sink_enable), .bias_enable(bias_enable), .sink_level(sink_level));
